/* File: logic/msf_flags.sv */
// multiplier status flags, sticky flags and the two 80-bit accumulators
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
// Notes on behaviour
// - each multiplier op rewrites negative, overflow, underflow, invalid flags
// - sticky flags at bits 6..9 hold until software clears them
// - flags registered at end of op cycle, visible next cycle
// - software write to status or sticky register beats the op update
// - underflow evaluated on every op, cleared when not underflowed
// - float product exponent below -126 sets underflow and its sticky
// - denormal float inputs count as zero, never underflow
// - signed fraction underflow: top 48 uniform, low 32 nonzero
// - unsigned fraction underflow: top 48 zero, low 32 nonzero
// - fraction underflow bits stay in accumulator low word
// - negative flag follows sign of signed fixed and non-special float results
// - float product exponent above 127 sets overflow and float sticky
// - signed fixed overflow: top 17 or 49 bits not uniform
// - unsigned fixed overflow: top 16 or 48 bits not zero
// - overflow bits stay in top word (fraction) or mid/top (integer)
// - float invalid on NaN input or infinity times zero
// - operations only set sticky flags, never clear them
// - no format given: signed fraction, signed-by-signed fraction
// - rounded mode treats inputs as fractions and rounds output
// - two 80-bit accumulators, word-addressable top, mid, low
module msf_flags (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire logic             op_valid,
  input  wire msf_pkg::msf_op_t op_code,
  input  wire logic             op_fmt_given,
  input  wire logic             op_x_signed,
  input  wire logic             op_y_signed,
  input  wire logic             op_integer,
  input  wire logic             op_rounded,
  input  wire logic             op_acc_sel,
  input  wire logic             op_to_mr,
  input  wire logic [1:0]       op_word_sel,
  input  wire logic [31:0]      op_x,
  input  wire logic [31:0]      op_y,
  output logic      [31:0]      op_result,
  output logic                  product_negative_flag,
  output logic                  product_overflow_flag,
  output logic                  product_underflow_flag,
  output logic                  product_invalid_flag,
  output logic                  sticky_fixed_overflow,
  output logic                  sticky_float_overflow,
  output logic                  sticky_underflow,
  output logic                  sticky_invalid_op
);
  import msf_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // each is top 16, mid 32 and low 32 bits of one result
  logic [79:0] product_accumulator [2]; // index 0 fg, 1 bg

  // ------------------------------------------------------------
  // operand format
  // ------------------------------------------------------------
  wire one_in   = (op_code == OP_SAT) || (op_code == OP_RND);
  // signedness and integer apply only when given; rounding applies even when not given and forces fraction
  wire sx       = op_fmt_given ? op_x_signed : 1'b1;
  wire sy       = op_fmt_given ? op_y_signed : 1'b1;
  wire is_int   = op_fmt_given & op_integer & ~op_rounded;
  wire signed_r = one_in ? sx : (sx | sy);

  // ------------------------------------------------------------
  // fixed-point product and accumulate
  // ------------------------------------------------------------
  wire [32:0] xe = {sx & op_x[31], op_x};
  wire [32:0] ye = {sy & op_y[31], op_y};

  wire signed [65:0] p66   = $signed(xe) * $signed(ye);
  // the exact product's top bit is the true sign; extending from
  // bit 63 would make +1.0 read as -1.0 and hide its overflow
  wire        [79:0] p80   = {{14{p66[65]}}, p66};

  // signed-by-signed fractions drop the redundant sign bit
  wire               drop  = sx & sy & ~is_int;
  wire        [79:0] prod  = drop ? {p80[78:0], 1'b0} : p80;
  wire        [79:0] src   = product_accumulator[op_acc_sel];
  wire        [79:0] sum   = src + prod;
  wire        [79:0] dif   = src - prod;

  // raw result before rounding or saturation
  logic [79:0] raw;
  always_comb begin
    case (op_code)
      OP_MAC_ADD: raw = sum;
      OP_MAC_SUB: raw = dif;
      OP_SAT:     raw = src;
      OP_RND:     raw = src;
      default:    raw = prod;
    endcase
  end

  // round to nearest at the mid/low boundary, fractions only
  wire do_rnd = ~is_int & ((op_code == OP_RND) | op_rounded);
  wire [79:0] rsum = raw + RND_HALF;
  wire [79:0] rnd  = {rsum[79:32], 32'h0000_0000};

  // ------------------------------------------------------------
  // fixed-point overflow checks on an 80-bit value
  // ------------------------------------------------------------
  wire [16:0] hi17 = raw[79:63];
  wire [48:0] hi49 = raw[79:31];
  wire ovf_sf = ~((&hi17) | ~(|hi17));
  wire ovf_si = ~((&hi49) | ~(|hi49));
  wire ovf_uf = |raw[79:64];
  wire ovf_ui = |raw[79:32];
  wire raw_ovf = signed_r ? (is_int ? ovf_si : ovf_sf)
                          : (is_int ? ovf_ui : ovf_uf);

  // saturation value for the chosen format
  wire [79:0] sat_s = is_int ? (raw[79] ? SAT_SI_N : SAT_SI_P)
                             : (raw[79] ? SAT_SF_N : SAT_SF_P);
  wire [79:0] sat_u = is_int ? SAT_UI : SAT_UF;
  wire [79:0] sat_v = signed_r ? sat_s : sat_u;

  // saturate replaces only a value that really overflowed
  // final result; unrounded fractions keep underflow bits low
  wire [79:0] res = (op_code == OP_SAT) ? (raw_ovf ? sat_v : raw)
                  : (do_rnd ? rnd : raw);

  // ------------------------------------------------------------
  // flags from the final fixed-point result
  // ------------------------------------------------------------
  wire [16:0] r17 = res[79:63];
  wire [48:0] r49 = res[79:31];
  wire [47:0] r48 = res[79:32];
  wire low_nz = |res[31:0];

  // signed limits need both-polarity uniformity
  wire fx_ovf_s = is_int ? ~((&r49) | ~(|r49))
                         : ~((&r17) | ~(|r17));
  wire fx_ovf_u = is_int ? (|res[79:32]) : (|res[79:64]);
  wire fx_ovf   = signed_r ? fx_ovf_s : fx_ovf_u;

  // integer results can never underflow
  wire fx_unf_s = ~is_int & ((&r48) | ~(|r48)) & low_nz;
  wire fx_unf_u = ~is_int & ~(|r48) & low_nz;
  wire fx_unf   = signed_r ? fx_unf_s : fx_unf_u;
  wire fx_neg   = signed_r & res[79];

  // ------------------------------------------------------------
  // floating-point product checks
  // ------------------------------------------------------------
  wire [7:0] ea = op_x[30:23];
  wire [7:0] eb = op_y[30:23];

  // denormals are flushed, so a zero exponent means zero
  wire za   = (ea == 8'h00);
  wire zb   = (eb == 8'h00);
  wire infa = (ea == FP_EXP_ONES) & ~(|op_x[22:0]);
  wire infb = (eb == FP_EXP_ONES) & ~(|op_y[22:0]);
  wire nana = (ea == FP_EXP_ONES) & (|op_x[22:0]);
  wire nanb = (eb == FP_EXP_ONES) & (|op_y[22:0]);
  wire fp_inv = nana | nanb | (infa & zb) | (za & infb);
  wire fp_special = za | zb | infa | infb | nana | nanb;

  // hidden one restored; special operands are masked later
  wire [23:0] ma = {1'b1, op_x[22:0]};
  wire [23:0] mb = {1'b1, op_y[22:0]};
  wire [47:0] mp = ma * mb;
  wire        nrm = mp[47];
  wire [22:0] mfr = nrm ? mp[46:24] : mp[45:23];
  wire        grd = nrm ? mp[23] : mp[22];
  // round to nearest only; no truncating mode is modelled
  // carry out of rounding bumps the exponent once more
  wire [23:0] mrn = {1'b0, mfr} + {23'h0, grd};
  wire        rcy = mrn[23];
  wire signed [10:0] eun = $signed({3'b000, ea}) + $signed({3'b000, eb})
                         - FP_BIAS2 + $signed({10'h0, nrm})
                         + $signed({10'h0, rcy});
  wire fp_ovf = ~fp_special & (eun > FP_EMAX);
  wire fp_unf = ~fp_special & (eun < FP_EMIN);
  wire fp_neg = (op_x[31] ^ op_y[31]) & ~fp_special;
  wire [7:0] fexp = 8'(eun + 11'sh07f);
  wire [31:0] fres = fp_special ? 32'h0000_0000
                   : {op_x[31] ^ op_y[31], fexp, mrn[22:0]};

  // ------------------------------------------------------------
  // next flag values for the issued operation
  // ------------------------------------------------------------
  logic next_neg;
  logic next_ovf;
  logic next_unf;
  logic next_inv;
  logic set_fo;
  logic set_vo;
  // plain transfers and clears leave the arithmetic flags at zero
  // set_ terms feed the stickies, which only ever collect them
  always_comb begin
    next_neg = 1'b0;
    next_ovf = 1'b0;
    next_unf = 1'b0;
    next_inv = 1'b0;
    set_fo   = 1'b0;
    set_vo   = 1'b0;
    case (op_code)
      OP_MUL, OP_MAC_ADD, OP_MAC_SUB, OP_SAT, OP_RND: begin
        next_neg = fx_neg;
        next_ovf = fx_ovf;
        next_unf = fx_unf;
        set_fo   = fx_ovf;
      end
      OP_FMUL: begin
        next_neg = fp_neg;
        next_ovf = fp_ovf;
        next_unf = fp_unf;
        next_inv = fp_inv;
        set_vo   = fp_ovf;
      end
      default: begin
        next_neg = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------
  // words: 0 status, 1 sticky, 2..4 fg, 5..7 bg; others read 0
  wire wr_arith  = reg_wr & (reg_addr == ADDR_ARITH);
  wire wr_sticky = reg_wr & (reg_addr == ADDR_STICKY);
  wire acc_hit   = (reg_addr >= ADDR_FG_LOW) & (reg_addr <= ADDR_BG_TOP);
  wire [3:0] acc_off = reg_addr - ADDR_FG_LOW;
  wire       bus_acc = (acc_off >= 4'h3);
  wire [1:0] bus_wrd = bus_acc ? 2'(acc_off - 4'h3) : acc_off[1:0];
  wire       wr_acc  = reg_wr & acc_hit;

  // read word of an accumulator; top word comes back sign-extended
  function automatic logic [31:0] acc_word(input logic [79:0] a,
                                           input logic [1:0] w);
    case (w)
      2'd0:    acc_word = a[31:0];
      2'd1:    acc_word = a[63:32];
      default: acc_word = {{16{a[79]}}, a[79:64]};
    endcase
  endfunction : acc_word

  wire [31:0] arith_status_reg = {28'h0, product_invalid_flag,
                                  product_underflow_flag,
                                  product_overflow_flag,
                                  product_negative_flag};

  wire [31:0] sticky_status_reg = {22'h0, sticky_invalid_op,
                                   sticky_underflow,
                                   sticky_float_overflow,
                                   sticky_fixed_overflow, 6'h00};

  wire [31:0] rd_mux = (reg_addr == ADDR_ARITH)  ? arith_status_reg
                     : (reg_addr == ADDR_STICKY) ? sticky_status_reg
                     : acc_hit ? acc_word(product_accumulator[bus_acc],
                                          bus_wrd)
                     : 32'h0000_0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // arithmetic flags: software write first, then the operation
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {product_invalid_flag, product_underflow_flag,
       product_overflow_flag, product_negative_flag} <= FLAG_RESET;
    end else if (wr_arith) begin
      // the written bits land as is, so software may clear a flag
      product_negative_flag  <= reg_wdata[NEG_BIT];
      product_overflow_flag  <= reg_wdata[OVF_BIT];
      product_underflow_flag <= reg_wdata[UNF_BIT];
      product_invalid_flag   <= reg_wdata[INV_BIT];
    end else if (op_valid) begin
      product_negative_flag  <= next_neg;
      product_overflow_flag  <= next_ovf;
      product_underflow_flag <= next_unf;
      product_invalid_flag   <= next_inv;
    end
  end

  // ------------------------------------------------------------
  // sticky flags: operations only ever OR in new bits
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {sticky_invalid_op, sticky_underflow,
       sticky_float_overflow, sticky_fixed_overflow} <= FLAG_RESET;
    end else if (wr_sticky) begin
      sticky_fixed_overflow <= reg_wdata[SFO_BIT];
      sticky_float_overflow <= reg_wdata[SVO_BIT];
      sticky_underflow      <= reg_wdata[SUN_BIT];
      sticky_invalid_op     <= reg_wdata[SIN_BIT];
    end else if (op_valid) begin
      sticky_fixed_overflow <= sticky_fixed_overflow | set_fo;
      sticky_float_overflow <= sticky_float_overflow | set_vo;
      sticky_underflow      <= sticky_underflow | next_unf;
      sticky_invalid_op     <= sticky_invalid_op | next_inv;
    end
  end

  // ------------------------------------------------------------
  // accumulators: bus write wins over the operation's write
  // ------------------------------------------------------------
  wire op_wr_res = op_valid & op_to_mr &
                   ((op_code == OP_MUL) | (op_code == OP_MAC_ADD) |
                    (op_code == OP_MAC_SUB) | (op_code == OP_SAT) |
                    (op_code == OP_RND));
  wire op_clr = op_valid & (op_code == OP_CLR);
  wire op_wrw = op_valid & (op_code == OP_WR_MR);

  // one writer per accumulator; mid-word writes sign-extend into top
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_acc
      // a bus write to this accumulator beats an op write to it
      wire bus_here = wr_acc & (bus_acc == 1'(gi));
      wire op_here  = (op_acc_sel == 1'(gi));
      wire [1:0] wsel = bus_here ? bus_wrd : op_word_sel;
      wire [31:0] wdat = bus_here ? reg_wdata : op_x;
      wire [79:0] cur = product_accumulator[gi];
      wire [79:0] wrd = (wsel == 2'd0) ? {cur[79:32], wdat}
                      : (wsel == 2'd1) ? {{16{wdat[31]}}, wdat, cur[31:0]}
                      : {wdat[15:0], cur[63:0]};
      always_ff @(posedge core_clk) begin
        if (rst) begin
          product_accumulator[gi] <= ACC_RESET;
        end else if (bus_here | (op_wrw & op_here)) begin
          product_accumulator[gi] <= wrd;
        end else if (op_clr & op_here) begin
          product_accumulator[gi] <= ACC_RESET;
        end else if (op_wr_res & op_here) begin
          product_accumulator[gi] <= res;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // register-file result: fraction from mid word, integer from low
  // ------------------------------------------------------------
  wire [31:0] fx_out = is_int ? res[31:0] : res[63:32];

  // clears and writes return zero, so no stale product leaks
  wire [31:0] next_result =
      (op_code == OP_FMUL)  ? fres
    : (op_code == OP_RD_MR) ? acc_word(src, op_word_sel)
    : ((op_code == OP_CLR) | (op_code == OP_WR_MR)) ? 32'h0000_0000
    : fx_out;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_result <= 32'h0000_0000;
    end else if (op_valid) begin
      op_result <= next_result;
    end
  end

endmodule : msf_flags

/* File: logic/msf_pkg.sv */
// package: constants and types for the multiplier status flag block
package msf_pkg;

  // ------------------------------------------------------------
  // register map (word offsets on the plain register port)
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_ARITH  = 4'h0;
  localparam logic [3:0] ADDR_STICKY = 4'h1;
  localparam logic [3:0] ADDR_FG_LOW = 4'h2;
  localparam logic [3:0] ADDR_FG_MID = 4'h3;
  localparam logic [3:0] ADDR_FG_TOP = 4'h4;
  localparam logic [3:0] ADDR_BG_LOW = 4'h5;
  localparam logic [3:0] ADDR_BG_MID = 4'h6;
  localparam logic [3:0] ADDR_BG_TOP = 4'h7;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int NEG_BIT  = 0;
  localparam int OVF_BIT  = 1;
  localparam int UNF_BIT  = 2;
  localparam int INV_BIT  = 3;
  localparam int SFO_BIT  = 6;
  localparam int SVO_BIT  = 7;
  localparam int SUN_BIT  = 8;
  localparam int SIN_BIT  = 9;
  localparam logic [3:0]  FLAG_RESET = 4'h0;
  localparam logic [79:0] ACC_RESET  = 80'h0;

  // ------------------------------------------------------------
  // arithmetic constants
  // ------------------------------------------------------------
  localparam logic [79:0] RND_HALF = 80'h0000_0000_0000_8000_0000;
  localparam logic [79:0] SAT_SF_P = 80'h0000_7fff_ffff_ffff_ffff;
  localparam logic [79:0] SAT_SF_N = 80'hffff_8000_0000_0000_0000;
  localparam logic [79:0] SAT_SI_P = 80'h0000_0000_0000_7fff_ffff;
  localparam logic [79:0] SAT_SI_N = 80'hffff_ffff_ffff_8000_0000;
  localparam logic [79:0] SAT_UF   = 80'h0000_ffff_ffff_ffff_ffff;
  localparam logic [79:0] SAT_UI   = 80'h0000_0000_0000_ffff_ffff;
  localparam logic signed [10:0] FP_BIAS2 = 11'sh0fe;
  localparam logic signed [10:0] FP_EMAX  = 11'sh07f;
  localparam logic signed [10:0] FP_EMIN  = -11'sh07e;
  localparam logic [7:0]  FP_EXP_ONES = 8'hff;

  // multiplier operations issued by the sequencer
  typedef enum logic [3:0] {
    OP_MUL, OP_MAC_ADD, OP_MAC_SUB, OP_SAT, OP_RND,
    OP_CLR, OP_WR_MR, OP_RD_MR, OP_FMUL
  } msf_op_t;

endpackage : msf_pkg

/* File: sim/msf_seq_model.sv */
// sequencer model that issues multiplier operations to the flag block
`timescale 1ns/1ns
module msf_seq_model
  import msf_pkg::*;
(
  input  wire logic        core_clk,
  output msf_pkg::msf_op_t op_code,
  output logic             op_valid,
  output logic [5:0]       op_fmt,
  output logic [31:0]      op_x,
  output logic [31:0]      op_y
);
  // idle at time zero, so nothing is issued while reset is held
  initial begin
    op_valid = 1'b0;
    op_code = OP_CLR;
    op_fmt = 6'h00;
    op_x = 32'h0;
    op_y = 32'h0;
  end
  // one op per call, held through the taking edge; operands are
  // inverted afterwards so a stale value is never mistaken for a live one
  task automatic issue(input msf_op_t c, input logic [5:0] f,
                       input logic [31:0] x, input logic [31:0] y);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_fmt <= f; // zero format field selects the default format
    op_x <= x;
    op_y <= y;
    @(posedge core_clk);
    op_valid <= 1'b0;
    op_x <= ~x;
    op_y <= ~y;
  endtask : issue
endmodule : msf_seq_model

/* File: sim/msf_flags_chk.sv */
// assertion checker for the multiplier status flag block
`timescale 1ns/1ns
module msf_flags_chk
  import msf_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic [3:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             op_valid,
  input wire msf_pkg::msf_op_t op_code,
  input wire logic             op_fmt_given,
  input wire logic             op_integer,
  input wire logic             op_rounded,
  input wire logic             product_negative_flag,
  input wire logic             product_overflow_flag,
  input wire logic             product_underflow_flag,
  input wire logic             product_invalid_flag,
  input wire logic             sticky_fixed_overflow,
  input wire logic             sticky_float_overflow,
  input wire logic             sticky_underflow,
  input wire logic             sticky_invalid_op
);
  // packed views in register bit order
  wire [3:0] ar = {product_invalid_flag, product_underflow_flag,
                   product_overflow_flag, product_negative_flag};
  wire [3:0] st = {sticky_invalid_op, sticky_underflow,
                   sticky_float_overflow, sticky_fixed_overflow};
  wire [3:0] w_ar = reg_wdata[3:0];
  wire [3:0] w_st = reg_wdata[9:6];
  wire quiet = !(reg_wr && reg_addr inside {ADDR_ARITH, ADDR_STICKY});
  wire fix_op = op_valid && quiet && op_code != OP_FMUL;
  wire flt_op = op_valid && quiet && op_code == OP_FMUL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rst; disable iff (1'b0) rst |=> ar == 4'h0 && st == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("flags not cleared");
  property p_hold; !(reg_wr && reg_addr == ADDR_STICKY) |=> (st & $past(st)) == $past(st); endproperty
  a_hold: assert property (p_hold) else $error("sticky lost");
  property p_fovf; fix_op ##1 product_overflow_flag |-> sticky_fixed_overflow; endproperty
  a_fovf: assert property (p_fovf) else $error("fixed sticky");
  property p_vovf; flt_op ##1 product_overflow_flag |-> sticky_float_overflow; endproperty
  a_vovf: assert property (p_vovf) else $error("float sticky");
  property p_unf; op_valid && quiet ##1 product_underflow_flag |-> sticky_underflow; endproperty
  a_unf: assert property (p_unf) else $error("underflow sticky");
  property p_inv; flt_op ##1 product_invalid_flag |-> sticky_invalid_op; endproperty
  a_inv: assert property (p_inv) else $error("invalid sticky");
  property p_fixinv; fix_op |=> !product_invalid_flag; endproperty
  a_fixinv: assert property (p_fixinv) else $error("fixed invalid");
  property p_xfer; fix_op && op_code inside {OP_CLR, OP_WR_MR, OP_RD_MR} |=> ar == 4'h0; endproperty
  a_xfer: assert property (p_xfer) else $error("transfer flags");
  property p_idle; !op_valid && !reg_wr |=> $stable(ar); endproperty
  a_idle: assert property (p_idle) else $error("flags moved idle");
  property p_intunf; fix_op && op_fmt_given && op_integer && !op_rounded && op_code inside {OP_MUL, OP_MAC_ADD, OP_MAC_SUB} |=> !product_underflow_flag; endproperty
  a_intunf: assert property (p_intunf) else $error("integer underflow");
  property p_war; reg_wr && reg_addr == ADDR_ARITH |=> ar == $past(w_ar); endproperty
  a_war: assert property (p_war) else $error("status write lost");
  property p_wst; reg_wr && reg_addr == ADDR_STICKY |=> st == $past(w_st); endproperty
  a_wst: assert property (p_wst) else $error("sticky write lost");
endmodule : msf_flags_chk

bind msf_flags msf_flags_chk u_chk (.core_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .op_valid, .op_code, .op_fmt_given, .op_integer, .op_rounded,
  .product_negative_flag, .product_overflow_flag, .product_underflow_flag,
  .product_invalid_flag, .sticky_fixed_overflow, .sticky_float_overflow,
  .sticky_underflow, .sticky_invalid_op);

/* File: sim/test_msf_flags.sv */
// self-checking testbench for the multiplier status flag block
`timescale 1ns/1ns
module test_msf_flags;
  import msf_pkg::*;
  logic        core_clk;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  wire  [31:0] reg_rdata;
  wire  [31:0] op_result;
  wire  [3:0]  fl;
  wire         op_valid;
  msf_op_t     op_code;
  wire  [5:0]  f;
  wire  [31:0] op_x;
  wire  [31:0] op_y;
  int          errors;
  int          checked;
  wire  [31:0] ar = {28'h0, fl};
  msf_seq_model seq (.core_clk, .op_code, .op_valid, .op_fmt(f), .op_x, .op_y);
  // flag bits and format bits are fanned out one per port
  msf_flags dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .op_valid, .op_code, .op_fmt_given(f[5]), .op_x_signed(f[4]),
    .op_y_signed(f[3]), .op_integer(f[2]), .op_rounded(f[1]),
    .op_acc_sel(1'b0), .op_to_mr(f[0]), .op_word_sel(2'h0), .op_x, .op_y,
    .op_result, .product_negative_flag(fl[0]), .product_overflow_flag(fl[1]),
    .product_underflow_flag(fl[2]), .product_invalid_flag(fl[3]),
    .sticky_fixed_overflow(), .sticky_float_overflow(),
    .sticky_underflow(), .sticky_invalid_op());
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_chk
  // flags are looked at in the cycle right after the taking edge
  task automatic op(input msf_op_t c, input logic [5:0] fm,
                    input logic [31:0] x, input logic [31:0] y,
                    input logic [31:0] exp);
    seq.issue(c, fm, x, y);
    #1 chk(ar, exp);
  endtask : op
  task automatic t_reset;
    rd_chk(ADDR_ARITH, 32'h0);
    rd_chk(ADDR_STICKY, 32'h0);
    rd_chk(4'h8, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fixed;
    op(OP_MUL, 6'h00, 32'h8000_0000, 32'h8000_0000, 32'h2);
    chk(op_result, 32'h8000_0000);
    rd_chk(ADDR_STICKY, 32'h40);
    op(OP_MUL, 6'h38, 32'h1, 32'h1, 32'h4);
    op(OP_MUL, 6'h38, 32'hffff_ffff, 32'h1, 32'h5);
    op(OP_CLR, 6'h01, 32'h0, 32'h0, 32'h0);
    op(OP_MUL, 6'h21, 32'h1, 32'h1, 32'h4);
    rd_chk(ADDR_FG_LOW, 32'h1);
    rd_chk(ADDR_STICKY, 32'h140);
    op(OP_MUL, 6'h02, 32'h1, 32'h4000_0000, 32'h0);
    chk(op_result, 32'h1);
    $display("test fixed done");
  endtask : t_fixed
  task automatic t_integer;
    op(OP_MUL, 6'h3c, 32'h7fff_ffff, 32'h2, 32'h2);
    op(OP_MUL, 6'h24, 32'h7fff_ffff, 32'h2, 32'h0);
    op(OP_MUL, 6'h25, 32'h0001_0000, 32'h0001_0000, 32'h2);
    rd_chk(ADDR_FG_MID, 32'h1);
    $display("test integer done");
  endtask : t_integer
  task automatic t_float;
    op(OP_FMUL, 6'h00, 32'h7f00_0000, 32'h4000_0000, 32'h2);
    op(OP_FMUL, 6'h00, 32'h0080_0000, 32'h3f00_0000, 32'h4);
    op(OP_FMUL, 6'h00, 32'h0000_0001, 32'h3f80_0000, 32'h0);
    op(OP_FMUL, 6'h00, 32'h7fc0_0000, 32'h3f80_0000, 32'h8);
    op(OP_FMUL, 6'h00, 32'h7f80_0000, 32'h0000_0001, 32'h8);
    op(OP_FMUL, 6'h00, 32'hc000_0000, 32'h4040_0000, 32'h1);
    rd_chk(ADDR_STICKY, 32'h3c0);
    $display("test float done");
  endtask : t_float
  // software write lands in the same cycle as a flag-raising op
  task automatic t_priority;
    fork
      seq.issue(OP_MUL, 6'h00, 32'h8000_0000, 32'h8000_0000);
      wr(ADDR_STICKY, 32'h0);
    join
    rd_chk(ADDR_STICKY, 32'h0);
    chk(ar, 32'h2);
    fork
      seq.issue(OP_MUL, 6'h00, 32'h8000_0000, 32'h8000_0000);
      wr(ADDR_ARITH, 32'h8);
    join
    rd_chk(ADDR_ARITH, 32'h8);
    rd_chk(ADDR_STICKY, 32'h40);
    wr(ADDR_STICKY, 32'h0);
    rd_chk(ADDR_STICKY, 32'h0);
    $display("test priority done");
  endtask : t_priority
  // accumulator ops on fg, bus writes on bg
  task automatic t_accum;
    op(OP_CLR, 6'h01, 32'h0, 32'h0, 32'h0);
    op(OP_MAC_ADD, 6'h01, 32'h4000_0000, 32'h4000_0000, 32'h0);
    chk(op_result, 32'h2000_0000);
    op(OP_MAC_ADD, 6'h01, 32'h7fff_ffff, 32'h7fff_ffff, 32'h2);
    op(OP_SAT, 6'h01, 32'h0, 32'h0, 32'h0);
    chk(op_result, 32'h7fff_ffff);
    op(OP_MAC_SUB, 6'h01, 32'h7fff_ffff, 32'h7fff_ffff, 32'h0);
    op(OP_RND, 6'h01, 32'h0, 32'h0, 32'h0);
    chk(op_result, 32'h2);
    op(OP_WR_MR, 6'h00, 32'h1234_5678, 32'h0, 32'h0);
    op(OP_RD_MR, 6'h00, 32'h0, 32'h0, 32'h0);
    chk(op_result, 32'h1234_5678);
    rd_chk(ADDR_FG_MID, 32'h2);
    wr(ADDR_BG_MID, 32'h8000_0000);
    rd_chk(ADDR_BG_TOP, 32'hffff_ffff);
    $display("test accum done");
  endtask : t_accum
  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // main sequence after a four cycle reset
  initial begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_fixed;
    t_integer;
    t_float;
    t_priority;
    t_accum;
    report_and_stop;
  end
  // the tests need well under 200 cycles, so this only trips on a hang
  initial begin
    repeat (2000) @(posedge core_clk);
    errors++;
    report_and_stop;
  end
endmodule : test_msf_flags
